/* File: hw/srst_defines.vh */
`ifndef SRST_DEFINES_VH
`define SRST_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SRST_ADDR_RXSC    12'h000
`define SRST_ADDR_TXSC    12'h004
`define SRST_ADDR_BAUDC   12'h008
`define SRST_ADDR_DIVL    12'h00C
`define SRST_ADDR_DIVH    12'h010
`define SRST_ADDR_RXDATA  12'h014
`define SRST_ADDR_TXDATA  12'h018
`define SRST_ADDR_IRQ     12'h01C
// ----------------------------------------
// receive_status_control fields
// ----------------------------------------
`define SRST_RX_PEN   7
`define SRST_RX_NINE  6
`define SRST_RX_SINGLE_RECEIVE_ENABLE  5
`define SRST_RX_CONTINUOUS_RECEIVE_ENABLE  4
`define SRST_RX_ADDRESS_DETECT_ENABLE 3
`define SRST_RX_FRAMING_ERROR_FLAG  2
`define SRST_RX_OVERRUN_ERROR_FLAG  1
`define SRST_RX_D9    0
// ----------------------------------------
// transmit_status_control fields
// ----------------------------------------
`define SRST_TX_CLOCK_SOURCE_SELECT  7
`define SRST_TX_NINE  6
`define SRST_TX_EN    5
`define SRST_TX_SYNC  4
`define SRST_TX_HIGH_SPEED_BAUD_SELECT  2
`define SRST_TX_TRMT  1
`define SRST_TX_D9    0
// ----------------------------------------
// baud_control and interrupt register fields
// ----------------------------------------
`define SRST_BC_WIDE   3
`define SRST_IRQ_RECEIVE_INTERRUPT_FLAG  0
`define SRST_IRQ_TRANSMIT_INTERRUPT_FLAG  1
`define SRST_IRQ_RECEIVE_INTERRUPT_ENABLE  2
`define SRST_IRQ_TRANSMIT_INTERRUPT_ENABLE  3
`define SRST_IRQ_PERIPHERAL_INTERRUPT_ENABLE  4
`define SRST_IRQ_GIE   5
`define SRST_IRQ_SLEEP 6
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRST_RST_BYTE 8'h00
`define SRST_RST_DIV  16'h0000
`endif

/* File: hw/srst_top.v */
// Summary of operation
// - Port enable on; async needs sync clear
// - Nine-bit select receives and reports ninth bit
// - Continuous receive starts only when enabled
// - Buffer load sets receive flag and interrupt
// - Data read returns oldest character low byte
// - Overrun sticks until continuous enable cleared
// - Address detect in nine-bit mode admits only ninth-bit-set characters
// - Admitted address characters show ninth bit one
// - Clearing address detect admits all characters
// - Sync set, clock source clear: slave
// - Slave transmits when both receive enables clear
// - Slave transmit like master, external clock
// - First word shifts, second waits, flag clear
// - After first shifts, second loads, flag sets
// - Transmit flag wakes sleep; global vectors
// - Transmit enable bit enables transmission
// - Writing transmit data starts transmission
// - Flags set regardless of enable bits
//
// The placing of the registers and the APB interface to the registers were decided locally.
`include "srst_defines.vh"
module srst_top #(
  parameter RX_DEPTH = 2
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_pin,
  input wire ck_pin,
  output reg dt_out,
  output reg dt_oe,
  output reg irq_out,
  output reg wake_out
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] rxsc_q;
  reg [7:0] txsc_q;
  reg [7:0] baudc_q;
  reg [15:0] div_q;
  reg [6:0] irqc_q;
  reg framing_error_flag_q, overrun_error_flag_q;
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg rx_s1_q, rx_s2_q, ck_s1_q, ck_s2_q, ck_prev_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_prev_q <= 1'b0;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      ck_s1_q <= ck_pin;
      ck_s2_q <= ck_s1_q;
      ck_prev_q <= ck_s2_q;
    end
  end
  wire ck_rise = ck_s2_q & ~ck_prev_q;
  wire ck_fall = ~ck_s2_q & ck_prev_q;
  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire pen = rxsc_q[`SRST_RX_PEN];
  wire sync_m = txsc_q[`SRST_TX_SYNC];
  wire async_rx_on = pen & ~sync_m & rxsc_q[`SRST_RX_CONTINUOUS_RECEIVE_ENABLE];
  wire slave_m = pen & sync_m & ~txsc_q[`SRST_TX_CLOCK_SOURCE_SELECT];
  wire slave_rx = slave_m & (rxsc_q[`SRST_RX_SINGLE_RECEIVE_ENABLE] | rxsc_q[`SRST_RX_CONTINUOUS_RECEIVE_ENABLE]);
  wire slave_tx = slave_m & ~rxsc_q[`SRST_RX_SINGLE_RECEIVE_ENABLE] & ~rxsc_q[`SRST_RX_CONTINUOUS_RECEIVE_ENABLE];
  wire rx_nine = rxsc_q[`SRST_RX_NINE];
  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  function hit;
    input [11:0] a;
    input [11:0] b;
    hit = (a == b);
  endfunction
  // ----------------------------------------
  // Baud tick: divisor and speed bits set the rate
  // ----------------------------------------
  reg [17:0] bcnt_q;
  wire [17:0] period = baudc_q[`SRST_BC_WIDE] ?
      ({2'b00, div_q} + 18'h00001) :
      ({10'h000, div_q[7:0]} + 18'h00001);
  wire [4:0] osr = txsc_q[`SRST_TX_HIGH_SPEED_BAUD_SELECT] ? 5'h04 : 5'h10;
  wire tick = (bcnt_q == 18'h00000);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bcnt_q <= 18'h00000;
    else if (tick)
      bcnt_q <= period - 18'h00001;
    else
      bcnt_q <= bcnt_q - 18'h00001;
  end
  // ----------------------------------------
  // Receive shifter (async oversampled, or slave sampled on clock)
  // ----------------------------------------
  reg [1:0] rst_q;
  reg [4:0] ov_q;
  reg [3:0] rbit_q;
  reg [8:0] rsr_q;
  reg rdone_q;
  reg rferr_q;
  localparam RS_IDLE = 2'b00, RS_START = 2'b01, RS_DATA = 2'b10, RS_STOP = 2'b11;
  wire [3:0] nbits = rx_nine ? 4'h9 : 4'h8;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q <= RS_IDLE;
      ov_q <= 5'h00;
      rbit_q <= 4'h0;
      rsr_q <= 9'h000;
      rdone_q <= 1'b0;
      rferr_q <= 1'b0;
    end else begin
      rdone_q <= 1'b0;
      if (slave_rx) begin
        rst_q <= RS_IDLE;
        if (ck_fall) begin
          rsr_q <= {rx_s2_q, rsr_q[8:1]};
          if (rbit_q == nbits - 4'h1) begin
            rbit_q <= 4'h0;
            rdone_q <= 1'b1;
            rferr_q <= 1'b0;
          end else
            rbit_q <= rbit_q + 4'h1;
        end
      end else if (!async_rx_on) begin
        rst_q <= RS_IDLE;
        rbit_q <= 4'h0;
      end else if (tick) begin
        case (rst_q)
          RS_IDLE: begin
            if (!rx_s2_q) begin
              rst_q <= RS_START;
              ov_q <= {1'b0, osr[4:1]} - 5'h01;
            end
          end
          RS_START: begin
            if (ov_q != 5'h00)
              ov_q <= ov_q - 5'h01;
            else if (rx_s2_q)
              rst_q <= RS_IDLE;
            else begin
              rst_q <= RS_DATA;
              ov_q <= osr - 5'h01;
              rbit_q <= 4'h0;
            end
          end
          RS_DATA: begin
            if (ov_q != 5'h00)
              ov_q <= ov_q - 5'h01;
            else begin
              ov_q <= osr - 5'h01;
              rsr_q <= {rx_s2_q, rsr_q[8:1]};
              if (rbit_q == nbits - 4'h1)
                rst_q <= RS_STOP;
              else
                rbit_q <= rbit_q + 4'h1;
            end
          end
          default: begin
            if (ov_q != 5'h00)
              ov_q <= ov_q - 5'h01;
            else begin
              rst_q <= RS_IDLE;
              rdone_q <= 1'b1;
              rferr_q <= ~rx_s2_q;
            end
          end
        endcase
      end
    end
  end
  // Eight-bit frames sit in rsr_q[8:1] and are right-aligned by the select, with no extra shift
  wire [8:0] rword = rx_nine ? rsr_q : {1'b0, rsr_q[8:1]};
  // ----------------------------------------
  // Receive buffer
  // ----------------------------------------
  reg [9:0] rbuf_q [0:RX_DEPTH-1];
  reg [1:0] rwp_q, rrp_q;
  reg [2:0] rcnt_q;
  wire admit = ~(rxsc_q[`SRST_RX_ADDRESS_DETECT_ENABLE] & rx_nine) | rword[8];
  wire rpush = rdone_q & admit & (rcnt_q != RX_DEPTH);
  wire rover = rdone_q & admit & (rcnt_q == RX_DEPTH);
  wire rpop = rd & hit(paddr, `SRST_ADDR_RXDATA) & (rcnt_q != 3'h0);
  wire [9:0] rhead = rbuf_q[rrp_q[0]];
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rwp_q <= 2'b00;
      rrp_q <= 2'b00;
      rcnt_q <= 3'h0;
      for (i = 0; i < RX_DEPTH; i = i + 1)
        rbuf_q[i] <= 10'h000;
    end else begin
      if (rpush) begin
        rbuf_q[rwp_q[0]] <= {rferr_q, rword};
        rwp_q <= rwp_q + 2'b01;
      end
      if (rpop)
        rrp_q <= rrp_q + 2'b01;
      if (rpush & ~rpop)
        rcnt_q <= rcnt_q + 3'h1;
      else if (rpop & ~rpush)
        rcnt_q <= rcnt_q - 3'h1;
    end
  end
  // ----------------------------------------
  // Transmit buffer and shifter (slave, external clock)
  // ----------------------------------------
  reg [8:0] txbuf_q;
  reg txfull_q;
  reg [9:0] tsr_q;
  reg [3:0] tleft_q;
  wire tx_on = txsc_q[`SRST_TX_EN] & slave_tx;
  wire txw = wr & hit(paddr, `SRST_ADDR_TXDATA);
  wire tsr_idle = (tleft_q == 4'h0);
  wire tload = tx_on & txfull_q & tsr_idle;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txbuf_q <= 9'h000;
      txfull_q <= 1'b0;
      tsr_q <= 10'h000;
      tleft_q <= 4'h0;
      dt_out <= 1'b1;
      dt_oe <= 1'b0;
    end else begin
      dt_oe <= tx_on;
      if (txw) begin
        txbuf_q <= {txsc_q[`SRST_TX_D9], pwdata[7:0]};
        txfull_q <= 1'b1;
      end else if (tload)
        txfull_q <= 1'b0;
      if (!tx_on)
        tleft_q <= 4'h0;
      else if (tload) begin
        tsr_q <= {1'b0, txbuf_q};
        tleft_q <= txsc_q[`SRST_TX_NINE] ? 4'h9 : 4'h8;
        dt_out <= txbuf_q[0];
      end else if (ck_rise & ~tsr_idle) begin
        // Bit goes out on rising edge, master samples late in the low phase
        tsr_q <= {1'b0, tsr_q[9:1]};
        dt_out <= tsr_q[1];
        tleft_q <= tleft_q - 4'h1;
      end
    end
  end
  // ----------------------------------------
  // Flags
  // ----------------------------------------
  wire receive_interrupt_flag = (rcnt_q != 3'h0);
  wire transmit_interrupt_flag = ~txfull_q;
  // Packed enables: [0] receive_interrupt_enable, [1] transmit_interrupt_enable, [3] peripheral_interrupt_enable, [4] gie
  wire irq_d = irqc_q[4] &
      ((receive_interrupt_flag & irqc_q[0]) | (transmit_interrupt_flag & irqc_q[1] & irqc_q[3]));
  wire wake_d = irqc_q[3] & irqc_q[1] & transmit_interrupt_flag;
  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxsc_q <= `SRST_RST_BYTE;
      txsc_q <= `SRST_RST_BYTE;
      baudc_q <= `SRST_RST_BYTE;
      div_q <= `SRST_RST_DIV;
      irqc_q <= 7'h00;
      framing_error_flag_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
      irq_out <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      irq_out <= irq_d;
      wake_out <= wake_d;
      if (wr & hit(paddr, `SRST_ADDR_RXSC))
        rxsc_q <= pwdata[7:0];
      if (wr & hit(paddr, `SRST_ADDR_TXSC))
        txsc_q <= pwdata[7:0];
      if (wr & hit(paddr, `SRST_ADDR_BAUDC))
        baudc_q <= pwdata[7:0];
      if (wr & hit(paddr, `SRST_ADDR_DIVL))
        div_q[7:0] <= pwdata[7:0];
      if (wr & hit(paddr, `SRST_ADDR_DIVH))
        div_q[15:8] <= pwdata[7:0];
      // Enables: rc_ie tx_ie pe_ie gie packed low
      if (wr & hit(paddr, `SRST_ADDR_IRQ))
        irqc_q <= {pwdata[`SRST_IRQ_SLEEP], pwdata[`SRST_IRQ_PERIPHERAL_INTERRUPT_ENABLE],
                   pwdata[`SRST_IRQ_GIE], pwdata[`SRST_IRQ_PERIPHERAL_INTERRUPT_ENABLE],
                   pwdata[`SRST_IRQ_TRANSMIT_INTERRUPT_ENABLE], pwdata[`SRST_IRQ_TRANSMIT_INTERRUPT_ENABLE],
                   pwdata[`SRST_IRQ_RECEIVE_INTERRUPT_ENABLE]};
      // Overrun set wins; cleared only by dropping continuous enable
      if (rover)
        overrun_error_flag_q <= 1'b1;
      else if (!rxsc_q[`SRST_RX_CONTINUOUS_RECEIVE_ENABLE])
        overrun_error_flag_q <= 1'b0;
      framing_error_flag_q <= (rcnt_q != 3'h0) ? rhead[9] : 1'b0;
    end
  end
  // ----------------------------------------
  // APB read and answer
  // ----------------------------------------
  wire known = hit(paddr, `SRST_ADDR_RXSC) | hit(paddr, `SRST_ADDR_TXSC) |
      hit(paddr, `SRST_ADDR_BAUDC) | hit(paddr, `SRST_ADDR_DIVL) |
      hit(paddr, `SRST_ADDR_DIVH) | hit(paddr, `SRST_ADDR_RXDATA) |
      hit(paddr, `SRST_ADDR_TXDATA) | hit(paddr, `SRST_ADDR_IRQ);
  reg [7:0] rdv;
  always @* begin
    rdv = 8'h00;
    case (paddr)
      `SRST_ADDR_RXSC:
        rdv = {rxsc_q[7:3], framing_error_flag_q, overrun_error_flag_q,
               rxsc_q[`SRST_RX_ADDRESS_DETECT_ENABLE] & rx_nine ? 1'b1 : rhead[8]};
      `SRST_ADDR_TXSC:
        rdv = {txsc_q[7:2], ~tx_on | tsr_idle, txsc_q[0]};
      `SRST_ADDR_BAUDC: rdv = baudc_q;
      `SRST_ADDR_DIVL: rdv = div_q[7:0];
      `SRST_ADDR_DIVH: rdv = div_q[15:8];
      `SRST_ADDR_RXDATA: rdv = rhead[7:0];
      `SRST_ADDR_IRQ:
        rdv = {1'b0, irqc_q[6], irqc_q[4], irqc_q[3], irqc_q[1], irqc_q[0],
               transmit_interrupt_flag, receive_interrupt_flag};
      default: rdv = 8'h00;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel & ~penable) begin
        prdata <= {24'h000000, rdv};
        pslverr <= ~known;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule

/* File: tb/srst_sva.sv */
module srst_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_pin,
  input wire logic ck_pin,
  input wire logic dt_out,
  input wire logic dt_oe,
  input wire logic irq_out,
  input wire logic wake_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Cycles since a shift-clock rise or a write
  // ----------------------------------------
  logic ck_q;
  logic [3:0] since_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_q <= 1'b0;
      since_q <= 4'hF;
    end else begin
      ck_q <= ck_pin;
      if ((ck_pin && !ck_q) || (pready && pwrite)) since_q <= 4'h0;
      else if (since_q != 4'hF) since_q <= since_q + 4'h1;
    end
  end
  a_ready_answer: assert property (psel && !penable |=> pready)
    else $error("no answer one cycle after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h01C |=> pslverr)
    else $error("unmapped access not refused");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returns data");
  a_byte_data: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_shift_cause: assert property (dt_oe && $past(dt_oe) && $changed(dt_out) |-> since_q < 4'h8)
    else $error("data out moved without clock or write");
  a_reset_quiet: assert property (presetn && !$past(presetn) |-> !pready && !irq_out && !wake_out)
    else $error("outputs active right after reset");
  cover property ($rose(wake_out));
  cover property ($rose(irq_out));
  cover property (pready && pslverr);
endmodule

bind srst_top srst_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_pin(rx_pin), .ck_pin(ck_pin), .dt_out(dt_out), .dt_oe(dt_oe),
  .irq_out(irq_out), .wake_out(wake_out));

/* File: tb/srst_far_model.sv */
module srst_far_model #(
  parameter int BIT_NS = 80
) (
  output logic rx_pin,
  output logic ck_pin,
  input wire logic dt_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rx_pin = 1'b1;
    ck_pin = 1'b0;
  end
  // Start low, data LSB first, stop high
  task automatic send(input logic [8:0] c, input int nb);
    rx_pin = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < nb; i++) begin
      rx_pin = c[i];
      #(BIT_NS);
    end
    rx_pin = 1'b1;
    #(BIT_NS);
  endtask
  // Clock only runs inside a frame; sample late in low phase
  task automatic shift(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      #20 v[i] = dt_out;
      #4 ck_pin = 1'b1;
      #24 ck_pin = 1'b0;
    end
  endtask
endmodule

/* File: tb/tb_top.sv */
`include "srst_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic [7:0] v;
  logic pready, pslverr, err, rx_pin, ck_pin, dt_out, dt_oe, irq_out, wake_out;
  int failures = 0;
  int n_compared = 0;
  always #2.5 pclk = ~pclk;
  srst_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .ck_pin(ck_pin), .dt_out(dt_out), .dt_oe(dt_oe),
    .irq_out(irq_out), .wake_out(wake_out));
  srst_far_model far (.rx_pin(rx_pin), .ck_pin(ck_pin), .dt_out(dt_out));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Registered outputs follow a write one edge later
  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_regs;
    rd(`SRST_ADDR_RXSC, 32'h0, "rxsc");
    rd(`SRST_ADDR_TXSC, 32'h2, "txsc");
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rdat);
  endtask
  task automatic t_rx;
    wr(`SRST_ADDR_DIVL, 32'h3);
    wr(`SRST_ADDR_TXSC, 32'h4);
    wr(`SRST_ADDR_RXSC, 32'h80);
    far.send(9'h011, 8);
    rd(`SRST_ADDR_IRQ, 32'h2, "irq");
    wr(`SRST_ADDR_RXSC, 32'h90);
    far.send(9'h0A5, 8);
    rd(`SRST_ADDR_IRQ, 32'h3, "irq");
    wr(`SRST_ADDR_IRQ, 32'h24);
    settle;
    chk("irq_out", 32'h1, {31'h0, irq_out});
    rd(`SRST_ADDR_RXDATA, 32'hA5, "rxdata");
    rd(`SRST_ADDR_IRQ, 32'h26, "irq");
  endtask
  task automatic t_ovr;
    far.send(9'h001, 8);
    far.send(9'h002, 8);
    far.send(9'h003, 8);
    rd(`SRST_ADDR_RXSC, 32'h92, "rxsc");
    rd(`SRST_ADDR_RXDATA, 32'h01, "rxdata");
    rd(`SRST_ADDR_RXDATA, 32'h02, "rxdata");
    wr(`SRST_ADDR_RXSC, 32'h80);
    rd(`SRST_ADDR_RXSC, 32'h80, "rxsc");
  endtask
  task automatic t_addr;
    wr(`SRST_ADDR_RXSC, 32'hD8);
    far.send(9'h055, 9);
    rd(`SRST_ADDR_IRQ, 32'h26, "irq");
    far.send(9'h142, 9);
    rd(`SRST_ADDR_RXSC, 32'hD9, "rxsc");
    rd(`SRST_ADDR_RXDATA, 32'h42, "rxdata");
    wr(`SRST_ADDR_RXSC, 32'hD0);
    far.send(9'h017, 9);
    rd(`SRST_ADDR_IRQ, 32'h27, "irq");
    rd(`SRST_ADDR_RXSC, 32'hD0, "rxsc");
    rd(`SRST_ADDR_RXDATA, 32'h17, "rxdata");
  endtask
  task automatic t_stx;
    wr(`SRST_ADDR_TXSC, 32'h30);
    wr(`SRST_ADDR_RXSC, 32'h90);
    settle;
    chk("dt_oe", 32'h0, {31'h0, dt_oe});
    wr(`SRST_ADDR_RXSC, 32'h80);
    settle;
    chk("dt_oe", 32'h1, {31'h0, dt_oe});
    wr(`SRST_ADDR_IRQ, 32'h18);
    wr(`SRST_ADDR_TXDATA, 32'h3C);
    wr(`SRST_ADDR_TXDATA, 32'h81);
    rd(`SRST_ADDR_IRQ, 32'h18, "irq");
    far.shift(v);
    chk("shift1", 32'h3C, {24'h0, v});
    rd(`SRST_ADDR_IRQ, 32'h1A, "irq");
    chk("wake", 32'h1, {31'h0, wake_out});
    far.shift(v);
    chk("shift2", 32'h81, {24'h0, v});
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_rx;
    t_ovr;
    t_addr;
    t_stx;
    tally_and_finish;
  end
  // Whole run needs about 8 us; a hang ends well after that
  initial begin
    #100000;
    failures++;
    tally_and_finish;
  end
endmodule
